// ---- design/sleep_wake_pkg.sv ----
// How it works
// RULE1: Transient interrupt wakes the system only when enabled.
// RULE2: Orientation interrupt wakes the system only when enabled.
// RULE3: Pulse interrupt wakes the system only when enabled.
// RULE4: Motion channel one wakes the system only when enabled.
// RULE5: Motion channel two wakes the system only when enabled.
// RULE6: Gate error clears when FIFO empties, stays set while un-emptied.
// RULE7: Interrupt polarity is selectable; the setting resets to zero.
// RULE8: With gating on, a sample before FIFO emptied sets gate error.
// RULE9: With gating on, a mode change freezes FIFO until it is emptied.
// RULE10: In sleep, any wake-enabled interrupt triggers the wake transition.
package sleep_wake_pkg;

    localparam int          NUM_SRC      = 5;
    localparam int          SRC_TRANS    = 0;
    localparam int          SRC_ORIENT   = 1;
    localparam int          SRC_PULSE    = 2;
    localparam int          SRC_MOT1     = 3;
    localparam int          SRC_MOT2     = 4;

    // Register byte offsets.
    localparam logic [7:0]  CTRL_OFF     = 8'h00;
    localparam logic [7:0]  STATUS_OFF   = 8'h04;
    localparam logic [7:0]  IRQ_STAT_OFF = 8'h08;
    localparam logic [7:0]  IRQ_MASK_OFF = 8'h0C;

    // Control register fields.
    localparam int          CTRL_WAKE_LSB = 0;
    localparam int          CTRL_GATE_BIT = 8;
    localparam int          CTRL_POL_BIT  = 9;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;

    // Status register fields.
    localparam int          ST_SLEEP_BIT  = 0;
    localparam int          ST_GERR_BIT   = 1;
    localparam int          ST_FROZEN_BIT = 2;

    // Interrupt status fields.
    localparam int          EV_WAKE       = 0;
    localparam int          EV_GERR       = 1;
    localparam int          NUM_EV        = 2;

    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef enum logic {MODE_WAKE, MODE_SLEEP} mode_t;

endpackage : sleep_wake_pkg

// ---- design/reg_bus_if.sv ----
`timescale 1ns/1ps
interface reg_bus_if;
    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        rd_en;
    logic [7:0]  rd_addr;
    logic [31:0] rd_data;
    logic        rd_ok;
    logic        wr_ok;

    modport slave  (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                    input rd_data, rd_ok, wr_ok);
    modport regs   (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                    output rd_data, rd_ok, wr_ok);
endinterface : reg_bus_if

// ---- design/axil_slave.sv ----
`timescale 1ns/1ps
module axil_slave
    import sleep_wake_pkg::*;
(
    // Clock and reset.
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write channels.
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read channels.
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Register side.
    reg_bus_if.slave         rb
);
    logic        aw_have_reg, aw_have_next;
    logic        w_have_reg, w_have_next;
    logic [7:0]  aw_addr_reg, aw_addr_next;
    logic [31:0] w_data_reg, w_data_next;
    logic [3:0]  w_strb_reg, w_strb_next;
    logic        bvalid_reg, bvalid_next;
    logic [1:0]  bresp_reg, bresp_next;
    logic        rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0]  rresp_reg, rresp_next;

    // Address and data are latched separately so either may arrive first.
    assign awready = !aw_have_reg && !bvalid_reg;
    assign wready  = !w_have_reg && !bvalid_reg;
    assign arready = !rvalid_reg;
    assign bvalid  = bvalid_reg;
    assign bresp   = bresp_reg;
    assign rvalid  = rvalid_reg;
    assign rdata   = rdata_reg;
    assign rresp   = rresp_reg;

    assign rb.wr_en   = aw_have_reg && w_have_reg && !bvalid_reg;
    assign rb.wr_addr = aw_addr_reg;
    assign rb.wr_data = w_data_reg;
    assign rb.wr_strb = w_strb_reg;
    assign rb.rd_en   = arvalid && arready;
    assign rb.rd_addr = araddr;

    always_comb begin
        aw_have_next = aw_have_reg;
        w_have_next  = w_have_reg;
        aw_addr_next = aw_addr_reg;
        w_data_next  = w_data_reg;
        w_strb_next  = w_strb_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        rvalid_next  = rvalid_reg;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        if (awvalid && awready) begin
            aw_have_next = 1'b1;
            aw_addr_next = awaddr;
        end
        if (wvalid && wready) begin
            w_have_next = 1'b1;
            w_data_next = wdata;
            w_strb_next = wstrb;
        end
        if (rb.wr_en) begin
            aw_have_next = 1'b0;
            w_have_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = rb.wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_reg && bready) begin
            bvalid_next = 1'b0;
        end
        if (rb.rd_en) begin
            rvalid_next = 1'b1;
            rdata_next  = rb.rd_data;
            rresp_next  = rb.rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_reg && rready) begin
            rvalid_next = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= 2'h0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= 2'h0;
        end else begin
            aw_have_reg <= aw_have_next;
            w_have_reg  <= w_have_next;
            aw_addr_reg <= aw_addr_next;
            w_data_reg  <= w_data_next;
            w_strb_reg  <= w_strb_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
        end
    end
endmodule : axil_slave

// ---- design/sleep_wake_source_select.sv ----
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module sleep_wake_source_select
    import sleep_wake_pkg::*;
(
    // Clock and reset.
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // AXI4-Lite register port.
    input  wire logic [7:0]         awaddr,
    input  wire logic               awvalid,
    output logic                    awready,
    input  wire logic [31:0]        wdata,
    input  wire logic [3:0]         wstrb,
    input  wire logic               wvalid,
    output logic                    wready,
    output logic [1:0]              bresp,
    output logic                    bvalid,
    input  wire logic               bready,
    input  wire logic [7:0]         araddr,
    input  wire logic               arvalid,
    output logic                    arready,
    output logic [31:0]             rdata,
    output logic [1:0]              rresp,
    output logic                    rvalid,
    input  wire logic               rready,
    // Function interrupts, active high, from the detectors.
    input  wire logic [NUM_SRC-1:0] func_irq,
    // Power mode control.
    input  wire logic               sleep_request,
    output logic                    sleeping,
    output logic                    wake_event,
    // FIFO interface.
    input  wire logic               sample_strobe,
    input  wire logic               fifo_empty,
    output logic                    sample_accept,
    // Interrupts.
    output logic [NUM_SRC-1:0]      irq_pin,
    output logic                    irq
);
    import sleep_wake_pkg::*;

    reg_bus_if rb ();

    axil_slave u_bus (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .rb      (rb)
    );

    ////////////////////////////////////////////////////////////////////////

    logic [31:0]       ctrl_reg, ctrl_next;
    logic [NUM_EV-1:0] ist_reg, ist_next;
    logic [NUM_EV-1:0] imask_reg, imask_next;
    mode_t             mode_reg, mode_next;
    logic              gerr_reg, gerr_next;
    logic              frozen_reg, frozen_next;
    logic              wake_reg, wake_next;
    logic [NUM_SRC-1:0] pin_reg, pin_next;

    logic [NUM_SRC-1:0] wake_en;
    logic [NUM_SRC-1:0] wake_src;
    logic              gate_en;
    logic              pol_high;
    logic              wake_hit;
    logic              gerr_set;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_bytes

    assign wake_en  = ctrl_reg[CTRL_WAKE_LSB +: NUM_SRC];
    assign gate_en  = ctrl_reg[CTRL_GATE_BIT];
    assign pol_high = ctrl_reg[CTRL_POL_BIT];

    // Bypassed functions cannot reach the wake path at all.
    assign wake_src = func_irq & wake_en; // RULE1 RULE2 RULE3 RULE4 RULE5
    assign wake_hit = (mode_reg == MODE_SLEEP) && |wake_src; // RULE10

    // A sample that lands while the previous contents are still unread.
    assign gerr_set = gate_en && sample_strobe && !fifo_empty; // RULE8

    // Samples are dropped while gated contents are frozen or unread.
    assign sample_accept = sample_strobe && !(gate_en
                           && (frozen_reg || !fifo_empty)); // RULE9

    assign sleeping   = (mode_reg == MODE_SLEEP);
    assign wake_event = wake_reg;
    assign irq_pin    = pin_reg;
    assign irq        = |(ist_reg & imask_reg);

    ////////////////////////////////////////////////////////////////////////

    always_comb begin
        ctrl_next    = ctrl_reg;
        imask_next   = imask_reg;
        ist_next     = ist_reg;
        mode_next    = mode_reg;
        gerr_next    = gerr_reg;
        frozen_next  = frozen_reg;
        wake_next    = 1'b0;
        rb.rd_data   = 32'h0000_0000;
        rb.rd_ok     = 1'b1;
        rb.wr_ok     = 1'b1;

        case (mode_reg)
            MODE_WAKE: begin
                if (sleep_request) begin
                    mode_next = MODE_SLEEP;
                end
            end
            MODE_SLEEP: begin
                if (wake_hit) begin
                    mode_next = MODE_WAKE; // RULE10
                    wake_next = 1'b1;
                end
            end
            default: mode_next = MODE_WAKE;
        endcase

        if (gate_en && (mode_next != mode_reg) && !fifo_empty) begin
            frozen_next = 1'b1; // RULE9
        end
        if (fifo_empty || !gate_en) begin
            frozen_next = 1'b0;
        end

        // Emptying clears; otherwise the flag holds while data is unread.
        if (fifo_empty) begin
            gerr_next = 1'b0; // RULE6
        end else if (gerr_set) begin
            gerr_next = 1'b1; // RULE8
        end

        // Reads: decode, and read-to-clear the event register.
        if (rb.rd_en) begin
            if (rb.rd_addr == CTRL_OFF) begin
                rb.rd_data = ctrl_reg;
            end else if (rb.rd_addr == STATUS_OFF) begin
                rb.rd_data[ST_SLEEP_BIT]  = (mode_reg == MODE_SLEEP);
                rb.rd_data[ST_GERR_BIT]   = gerr_reg;
                rb.rd_data[ST_FROZEN_BIT] = frozen_reg;
            end else if (rb.rd_addr == IRQ_STAT_OFF) begin
                rb.rd_data[NUM_EV-1:0] = ist_reg;
                ist_next = '0;
            end else if (rb.rd_addr == IRQ_MASK_OFF) begin
                rb.rd_data[NUM_EV-1:0] = imask_reg;
            end else begin
                rb.rd_ok = 1'b0;
            end
        end

        if (rb.wr_en) begin
            if (rb.wr_addr == CTRL_OFF) begin
                ctrl_next = merge_bytes(ctrl_reg, rb.wr_data, rb.wr_strb)
                            & 32'h0000_03FF;
            end else if (rb.wr_addr == IRQ_MASK_OFF) begin
                if (rb.wr_strb[0]) begin
                    imask_next = rb.wr_data[NUM_EV-1:0];
                end
            end else if (rb.wr_addr == STATUS_OFF
                         || rb.wr_addr == IRQ_STAT_OFF) begin
                rb.wr_ok = 1'b1;
            end else begin
                rb.wr_ok = 1'b0;
            end
        end

        // Events are applied after the clear so that a same-cycle set wins.
        if (wake_next) begin
            ist_next[EV_WAKE] = 1'b1;
        end
        if (gerr_next && !gerr_reg) begin
            ist_next[EV_GERR] = 1'b1;
        end
    end

    // Polarity applies to every function pin; zero selects active low.
    always_comb begin
        for (int i = 0; i < NUM_SRC; i++) begin
            pin_next[i] = pol_high ? func_irq[i] : !func_irq[i]; // RULE7
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg    <= CTRL_RESET; // RULE7
            imask_reg   <= '0;
            ist_reg     <= '0;
            mode_reg    <= MODE_WAKE;
            gerr_reg    <= 1'b0;
            frozen_reg  <= 1'b0;
            wake_reg    <= 1'b0;
            pin_reg     <= {NUM_SRC{1'b1}};
        end else begin
            ctrl_reg    <= ctrl_next;
            imask_reg   <= imask_next;
            ist_reg     <= ist_next;
            mode_reg    <= mode_next;
            gerr_reg    <= gerr_next;
            frozen_reg  <= frozen_next;
            wake_reg    <= wake_next;
            pin_reg     <= pin_next;
        end
    end
endmodule : sleep_wake_source_select

// ---- testbench/sleep_wake_monitor.sv ----
`timescale 1ns/1ps
module sleep_wake_monitor
    import sleep_wake_pkg::*;
(
    // Clock and reset.
    input wire logic               aclk,
    input wire logic               aresetn,
    // Bus responses.
    input wire logic               bvalid,
    input wire logic               bready,
    input wire logic [1:0]         bresp,
    input wire logic               rvalid,
    input wire logic               rready,
    input wire logic [31:0]        rdata,
    // Mode, FIFO and pins.
    input wire logic [NUM_SRC-1:0] func_irq,
    input wire logic               sleep_request,
    input wire logic               sleeping,
    input wire logic               wake_event,
    input wire logic               sample_strobe,
    input wire logic               sample_accept,
    input wire logic [NUM_SRC-1:0] irq_pin
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_wake_cause;
        wake_event |-> $past(sleeping) && !sleeping && $past(func_irq) != 0;
    endproperty
    a_wake_cause: assert property (p_wake_cause)
        else $error("wake pulse without a sleeping cause");
    property p_no_silent_wake;
        $past(aresetn) && $past(sleeping) && !sleeping |-> wake_event;
    endproperty
    a_no_silent_wake: assert property (p_no_silent_wake)
        else $error("left sleep without a wake pulse");
    property p_wake_pulse;
        wake_event |=> !wake_event && !sleeping;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse)
        else $error("wake pulse longer than one cycle");
    property p_sleep_enter;
        !sleeping && sleep_request |=> sleeping;
    endproperty
    a_sleep_enter: assert property (p_sleep_enter)
        else $error("sleep request not followed");
    property p_accept;
        sample_accept |-> sample_strobe;
    endproperty
    a_accept: assert property (p_accept)
        else $error("sample accepted without a strobe");
    property p_pin_reset;
        disable iff (1'b0) !aresetn |=> irq_pin == 5'h1F;
    endproperty
    a_pin_reset: assert property (p_pin_reset)
        else $error("pins not idle after reset");
    property p_pin_follow;
        $past(aresetn) |->
            irq_pin == $past(func_irq) || irq_pin == ~$past(func_irq);
    endproperty
    a_pin_follow: assert property (p_pin_follow)
        else $error("pin does not follow its function");
    property p_b_hold;
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped early");
    property p_r_hold;
        rvalid && !rready |=> rvalid && $stable(rdata);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read response dropped early");
endmodule : sleep_wake_monitor

bind sleep_wake_source_select sleep_wake_monitor i_sleep_wake_monitor (
    .aclk(aclk), .aresetn(aresetn), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .func_irq(func_irq), .sleep_request(sleep_request),
    .sleeping(sleeping), .wake_event(wake_event),
    .sample_strobe(sample_strobe), .sample_accept(sample_accept),
    .irq_pin(irq_pin));

// ---- testbench/sleep_wake_source_select_tb.sv ----
`timescale 1ns/1ps
module sleep_wake_source_select_tb;
    import sleep_wake_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, rsp;
    logic [NUM_SRC-1:0] func_irq = 5'h00, irq_pin;
    logic sleep_request = 1'b0, sample_strobe = 1'b0, fifo_empty = 1'b1;
    logic sleeping, wake_event, sample_accept;
    int err_total = 0;
    int check_count = 0;

    sleep_wake_source_select i_sleep_wake_source_select (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .func_irq(func_irq), .sleep_request(sleep_request),
        .sleeping(sleeping), .wake_event(wake_event),
        .sample_strobe(sample_strobe), .fifo_empty(fifo_empty),
        .sample_accept(sample_accept), .irq_pin(irq_pin), .irq(irq));

    initial begin
        forever #2 aclk = ~aclk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (err_total == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic hang();
        err_total++;
        report_and_stop();
    endtask : hang

    // Both channels are offered at once; each drops only when taken.
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       output logic [1:0] r);
        int n;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 50) hang();
        r = bresp;
        bready <= 1'b0;
    endtask : axw

    task automatic axr(input logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        int n;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 50) hang();
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axr

    task automatic go_sleep();
        @(posedge aclk);
        sleep_request <= 1'b1;
        @(posedge aclk);
        sleep_request <= 1'b0;
        #1 chk("sleeping", sleeping, 1);
    endtask : go_sleep

    task automatic strobe(input logic exp);
        @(posedge aclk);
        sample_strobe <= 1'b1;
        #1 chk("sample_accept", sample_accept, exp);
        @(posedge aclk);
        sample_strobe <= 1'b0;
    endtask : strobe

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("irq_pin", irq_pin, 5'h1F);
        axr(CTRL_OFF, rd, rsp);
        chk("ctrl", rd, CTRL_RESET);
        axr(STATUS_OFF, rd, rsp);
        chk("status", rd, 32'h0);
    endtask : t_reset

    // Every other source fires first and must be ignored while asleep.
    task automatic t_wake();
        for (int i = 0; i < NUM_SRC; i++) begin
            axw(CTRL_OFF, 32'h1 << i, rsp);
            go_sleep();
            @(posedge aclk);
            func_irq <= ~(5'h01 << i);
            @(posedge aclk);
            #1 chk("bypass", sleeping, 1);
            @(posedge aclk);
            func_irq <= 5'h1F;
            @(posedge aclk);
            #1 chk("wake", wake_event, 1);
            chk("awake", sleeping, 0);
            @(posedge aclk);
            func_irq <= 5'h00;
        end
    endtask : t_wake

    task automatic t_gate();
        axw(CTRL_OFF, 32'h100, rsp);
        @(posedge aclk);
        fifo_empty <= 1'b0;
        strobe(1'b0);
        axr(STATUS_OFF, rd, rsp);
        chk("gate_err", rd, 32'h2);
        axr(STATUS_OFF, rd, rsp);
        chk("gate_err_held", rd, 32'h2);
        @(posedge aclk);
        fifo_empty <= 1'b1;
        axr(STATUS_OFF, rd, rsp);
        chk("gate_err_clr", rd, 32'h0);
    endtask : t_gate

    task automatic t_irq();
        chk("irq_masked", irq, 0);
        axw(IRQ_MASK_OFF, 32'h3, rsp);
        #1 chk("irq", irq, 1);
        axr(IRQ_STAT_OFF, rd, rsp);
        chk("irq_status", rd, 32'h3);
        @(posedge aclk);
        #1 chk("irq_clr", irq, 0);
        axr(IRQ_STAT_OFF, rd, rsp);
        chk("irq_status_clr", rd, 32'h0);
        axr(IRQ_MASK_OFF, rd, rsp);
        chk("irq_mask", rd, 32'h3);
    endtask : t_irq

    task automatic t_freeze();
        @(posedge aclk);
        fifo_empty <= 1'b0;
        go_sleep();
        axr(STATUS_OFF, rd, rsp);
        chk("frozen", rd, 32'h5);
        strobe(1'b0);
        @(posedge aclk);
        fifo_empty <= 1'b1;
        strobe(1'b1);
        axr(STATUS_OFF, rd, rsp);
        chk("thawed", rd, 32'h1);
    endtask : t_freeze

    task automatic t_pol();
        @(posedge aclk);
        func_irq <= 5'h05;
        repeat (2) @(posedge aclk);
        #1 chk("pin_low", irq_pin, 5'h1A);
        axw(CTRL_OFF, 32'h300, rsp);
        @(posedge aclk);
        #1 chk("pin_high", irq_pin, 5'h05);
        chk("asleep", sleeping, 1);
        @(posedge aclk);
        func_irq <= 5'h00;
    endtask : t_pol

    task automatic t_unmapped();
        axw(8'h10, 32'hFFFF_FFFF, rsp);
        chk("bresp", rsp, RESP_SLVERR);
        axr(8'h10, rd, rsp);
        chk("rresp", rsp, RESP_SLVERR);
        axw(STATUS_OFF, 32'hFFFF_FFFF, rsp);
        chk("bresp_ro", rsp, RESP_OKAY);
        axr(STATUS_OFF, rd, rsp);
        chk("status_ro", rd, 32'h1);
        axr(CTRL_OFF, rd, rsp);
        chk("ctrl_kept", rd, 32'h300);
        chk("rresp_ok", rsp, RESP_OKAY);
    endtask : t_unmapped

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_wake();
        t_gate();
        t_irq();
        t_freeze();
        t_pol();
        t_unmapped();
        report_and_stop();
    end
endmodule : sleep_wake_source_select_tb
